// [logic/mdt_timer.sv]
/*
 multi-channel down timer: four down counters behind an axi4-lite slave.
 assumes one 25 MHz clock, synchronous active-high reset, single-beat
 accesses, one write and one read outstanding at most.

*/
`timescale 1ns/100ps
`include "mdt_map.svh"
module mdt_timer
   import mdt_pkg::*;
(
   input  wire logic        clk,           // 25 MHz system clock
   input  wire logic        srst,          // synchronous reset, active high
   input  wire logic [7:0]  s_axi_awaddr,  // write address
   input  wire logic        s_axi_awvalid, // write address valid
   output logic             s_axi_awready, // write address ready
   input  wire logic [31:0] s_axi_wdata,   // write data
   input  wire logic [3:0]  s_axi_wstrb,   // write byte enables
   input  wire logic        s_axi_wvalid,  // write data valid
   output logic             s_axi_wready,  // write data ready
   output logic [1:0]       s_axi_bresp,   // write response
   output logic             s_axi_bvalid,  // write response valid
   input  wire logic        s_axi_bready,  // write response ready
   input  wire logic [7:0]  s_axi_araddr,  // read address
   input  wire logic        s_axi_arvalid, // read address valid
   output logic             s_axi_arready, // read address ready
   output logic [31:0]      s_axi_rdata,   // read data
   output logic [1:0]       s_axi_rresp,   // read response
   output logic             s_axi_rvalid,  // read valid
   input  wire logic        s_axi_rready,  // read ready
   output logic [3:0]       chan_irq       // per-channel interrupt request
);
   localparam int NCH = `MDT_NUM_CH;
   localparam int CW  = `MDT_CNT_W;

   // decode of an address into a channel register; used by both bus paths
   function automatic logic ch_hit(input logic [7:0] a, input logic [3:0] off);
      ch_hit = (a[7:6] == 2'h0) && (a[3:0] == off);
   endfunction

   // channel state
   logic [CW-1:0] period   [NCH];      // programmed period
   logic [CW-1:0] count    [NCH];      // live counter
   logic [CW-1:0] pending  [NCH];      // deferred period awaiting interval end
   logic [NCH-1:0] pend_v;             // deferred period waiting
   logic [NCH-1:0] run_flag;           // counting_run_flag
   logic [NCH-1:0] irq_flag;           // expiry_interrupt_flag
   logic [NCH-1:0] irq_en;             // expiry_interrupt_enable
   mdt_mode_t      mode    [NCH];      // per-channel mode
   logic [NCH-1:0] in_use;             // channel_in_use_flag
   logic           multi_task_select;  // module_config field
   logic [CW-1:0]  next_period [NCH];
   logic [CW-1:0]  next_count  [NCH];
   logic [CW-1:0]  next_pending[NCH];
   logic [NCH-1:0] next_pend_v, next_run_flag, next_irq_flag, next_irq_en, next_in_use;
   mdt_mode_t      next_mode [NCH];
   logic           next_multi_task_select;

   // bus state
   mdt_bus_t       bus_st, next_bus_st;
   logic [7:0]     aw_q, next_aw_q;    // captured write address
   logic [31:0]    w_q, next_w_q;      // captured write data
   logic           aw_v, next_aw_v, w_v, next_w_v;
   logic [1:0]     bresp_q, next_bresp_q;
   logic [31:0]    rdata_q, next_rdata_q;
   logic [1:0]     rresp_q, next_rresp_q;
   logic           wr_fire;            // write applied this cycle
   logic           rd_fire;            // read accepted this cycle
   logic [NCH-1:0] idle_claim;         // one-hot claim by an idle read
   logic [NCH-1:0] free_vec;           // channels available
   logic [2:0]     lowest_free;        // index, 4 means none free

   // full-word write only; partial strobes are taken as full to keep fields coherent
   assign s_axi_awready = (bus_st == MDT_BUS_IDLE) && !aw_v;
   assign s_axi_wready  = (bus_st == MDT_BUS_IDLE) && !w_v;
   assign s_axi_arready = (bus_st == MDT_BUS_IDLE) && !aw_v && !w_v && !s_axi_awvalid;
   assign s_axi_bvalid  = (bus_st == MDT_BUS_BRESP);
   assign s_axi_rvalid  = (bus_st == MDT_BUS_RRESP);
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = rdata_q;
   assign wr_fire = (bus_st == MDT_BUS_IDLE) && aw_v && w_v;
   assign rd_fire = s_axi_arvalid && s_axi_arready;

   // lowest free channel; a free channel is one not in use in multi-task mode, else one not running
   always_comb begin
      free_vec    = multi_task_select ? ~in_use : ~run_flag;
      lowest_free = 3'h4;
      for (int i = NCH - 1; i >= 0; i--) begin
         if (free_vec[i]) begin
            lowest_free = 3'(i);
         end
      end
   end

   // reading the idle register in multi-task mode claims the channel
   always_comb begin
      idle_claim = '0;
      if (rd_fire && multi_task_select && s_axi_araddr == `MDT_OFF_IDLE
          && lowest_free != 3'h4) begin
         idle_claim[lowest_free[1:0]] = 1'b1;
      end
   end

   // bus next-state: capture address and data in either order, answer after both
   always_comb begin
      next_bus_st  = bus_st;
      next_aw_q    = aw_q;
      next_w_q     = w_q;
      next_aw_v    = aw_v;
      next_w_v     = w_v;
      next_bresp_q = bresp_q;
      next_rdata_q = rdata_q;
      next_rresp_q = rresp_q;
      unique case (bus_st)
         MDT_BUS_IDLE: begin
            if (s_axi_awvalid && s_axi_awready) begin
               next_aw_q = s_axi_awaddr;
               next_aw_v = 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
               next_w_q = s_axi_wdata;
               next_w_v = 1'b1;
            end
            if (wr_fire) begin
               next_aw_v    = 1'b0;
               next_w_v     = 1'b0;
               next_bus_st  = MDT_BUS_BRESP;
               next_bresp_q = (aw_q[7:6] == 2'h0 || aw_q == `MDT_OFF_MODULE_CONFIG ||
                               aw_q == `MDT_OFF_CHANNEL_IN_USE_FLAG) ? `MDT_RESP_OKAY : `MDT_RESP_SLVERR;
            end else if (rd_fire) begin
               next_bus_st  = MDT_BUS_RRESP;
               next_rresp_q = `MDT_RESP_OKAY;
               next_rdata_q = '0;
               if (s_axi_araddr[7:6] == 2'h0) begin
                  if (ch_hit(s_axi_araddr, `MDT_OFF_PERIOD)) begin
                     next_rdata_q[CW-1:0] = period[s_axi_araddr[5:4]];
                  end else if (ch_hit(s_axi_araddr, `MDT_OFF_COUNT)) begin
                     next_rdata_q[CW-1:0] = count[s_axi_araddr[5:4]];
                  end else if (ch_hit(s_axi_araddr, `MDT_OFF_CTRL)) begin
                     // enables read back as in force
                     next_rdata_q[`MDT_CTRL_IE_BIT] = irq_en[s_axi_araddr[5:4]];
                     next_rdata_q[`MDT_CTRL_MODE_LO +: 2] = mode[s_axi_araddr[5:4]];
                  end else begin
                     next_rdata_q[`MDT_STAT_IRQ_BIT] = irq_flag[s_axi_araddr[5:4]];
                     next_rdata_q[`MDT_STAT_RUN_BIT] = run_flag[s_axi_araddr[5:4]];
                  end
               end else if (s_axi_araddr == `MDT_OFF_MODULE_CONFIG) begin
                  next_rdata_q[0] = multi_task_select;
               end else if (s_axi_araddr == `MDT_OFF_IDLE) begin
                  next_rdata_q[2:0] = lowest_free;
               end else if (s_axi_araddr == `MDT_OFF_CHANNEL_IN_USE_FLAG) begin
                  next_rdata_q[NCH-1:0] = in_use;
               end else begin
                  next_rresp_q = `MDT_RESP_SLVERR;
               end
            end
         end
         MDT_BUS_BRESP: begin
            if (s_axi_bready) begin
               next_bus_st = MDT_BUS_IDLE;
            end
         end
         MDT_BUS_RRESP: begin
            if (s_axi_rready) begin
               next_bus_st = MDT_BUS_IDLE;
            end
         end
         default: begin
            next_bus_st = MDT_BUS_IDLE;
         end
      endcase
   end

   // one identical channel instance per index
   for (genvar c = 0; c < NCH; c++) begin : g_ch
      logic wsel;  // write targets this channel
      assign wsel = wr_fire && aw_q[7:6] == 2'h0 && aw_q[5:4] == 2'(c);
      always_comb begin
         next_period[c]  = period[c];
         next_count[c]   = count[c];
         next_pending[c] = pending[c];
         next_pend_v[c]  = pend_v[c];
         next_run_flag[c] = run_flag[c];
         next_irq_flag[c] = irq_flag[c];
         next_irq_en[c]  = irq_en[c];
         next_mode[c]    = mode[c];
         if (run_flag[c]) begin
            if (count[c] != '0) begin
               next_count[c] = count[c] - CW'(1);
            end else begin
               next_irq_flag[c] = 1'b1;
               if (mode[c] == MDT_REPEAT_INTERRUPT_MODE) begin
                  // deferred period takes effect at interval end
                  next_period[c] = pend_v[c] ? pending[c] : period[c];
                  next_count[c]  = pend_v[c] ? pending[c] : period[c];
                  next_pend_v[c] = 1'b0;
               end else begin
                  next_run_flag[c] = 1'b0;
               end
            end
         end
         if (wsel && ch_hit(aw_q, `MDT_OFF_PERIOD)) begin
            // one-shot modes, force-load, idle or immediate all load now
            // a deferred value in stall mode would be lost, as it never reloads
            // force-load bit
            if (w_q[`MDT_LOAD_BIT] || !w_q[`MDT_PERIOD_DEFER_BIT] || !run_flag[c]
                || mode[c] != MDT_REPEAT_INTERRUPT_MODE) begin
               next_period[c]  = w_q[CW-1:0];
               next_count[c]   = w_q[CW-1:0];
               next_pend_v[c]  = 1'b0;
               next_run_flag[c] = (w_q[CW-1:0] != '0);
            end else begin
               next_pending[c] = w_q[CW-1:0];
               next_pend_v[c]  = 1'b1;
            end
         end
         if (wsel && ch_hit(aw_q, `MDT_OFF_CTRL)) begin
            next_irq_en[c] = w_q[`MDT_CTRL_IE_BIT];
            // per-channel mode; the unused code maps to repeat
            next_mode[c] = (w_q[`MDT_CTRL_MODE_LO +: 2] == 2'h3) ? MDT_REPEAT_INTERRUPT_MODE
                           : mdt_mode_t'(w_q[`MDT_CTRL_MODE_LO +: 2]);
            if (w_q[`MDT_CTRL_STOP_BIT]) begin
               next_run_flag[c] = 1'b0;
               next_count[c]    = '0;
               next_pend_v[c]   = 1'b0;
            end
         end
         // mask clear; a same-cycle expiry wins
         if (wsel && ch_hit(aw_q, `MDT_OFF_STAT) && w_q[`MDT_STAT_IRQ_BIT]
             && !(run_flag[c] && count[c] == '0)) begin
            next_irq_flag[c] = 1'b0;
         end
         // claim by idle read, release only by software
         next_in_use[c] = in_use[c];
         if (idle_claim[c]) begin
            next_in_use[c] = 1'b1;
         end else if (wr_fire && aw_q == `MDT_OFF_CHANNEL_IN_USE_FLAG && w_q[c]) begin
            next_in_use[c] = 1'b0;
         end
      end
      // request only while enabled and flagged
      assign chan_irq[c] = irq_flag[c] && irq_en[c];
   end

   always_comb begin
      next_multi_task_select = multi_task_select;
      if (wr_fire && aw_q == `MDT_OFF_MODULE_CONFIG) begin
         next_multi_task_select = w_q[0];
      end
   end

   // register everything; reset to stopped, repeat mode, hardware-status mode
   always_ff @(posedge clk) begin
      if (srst) begin
         bus_st <= MDT_BUS_IDLE;
         aw_q <= '0; w_q <= '0; aw_v <= 1'b0; w_v <= 1'b0;
         bresp_q <= '0; rdata_q <= '0; rresp_q <= '0;
         pend_v <= '0; run_flag <= '0; irq_flag <= '0; irq_en <= '0; in_use <= '0;
         multi_task_select <= 1'b0;
         for (int i = 0; i < NCH; i++) begin
            period[i] <= '0; count[i] <= '0; pending[i] <= '0;
            mode[i] <= MDT_REPEAT_INTERRUPT_MODE;
         end
      end else begin
         bus_st <= next_bus_st;
         aw_q <= next_aw_q; w_q <= next_w_q; aw_v <= next_aw_v; w_v <= next_w_v;
         bresp_q <= next_bresp_q; rdata_q <= next_rdata_q; rresp_q <= next_rresp_q;
         pend_v <= next_pend_v; run_flag <= next_run_flag; irq_flag <= next_irq_flag;
         irq_en <= next_irq_en; in_use <= next_in_use;
         multi_task_select <= next_multi_task_select;
         for (int i = 0; i < NCH; i++) begin
            period[i] <= next_period[i]; count[i] <= next_count[i];
            pending[i] <= next_pending[i]; mode[i] <= next_mode[i];
         end
      end
   end

   // expiry followed by a flag set one cycle later
   sequence s_expire;
      run_flag[0] && count[0] == '0;
   endsequence
   chk_expiry_sets_flag: assert property (@(posedge clk) disable iff (srst)
      s_expire |=> irq_flag[0]) else $error("expiry did not set flag");
   chk_stall_stops_run: assert property (@(posedge clk) disable iff (srst)
      (s_expire and (!wr_fire && mode[0] != MDT_REPEAT_INTERRUPT_MODE)) |=> !run_flag[0])
      else $error("one-shot did not stop");
   chk_repeat_reloads: assert property (@(posedge clk) disable iff (srst)
      (s_expire and (mode[0] == MDT_REPEAT_INTERRUPT_MODE && !wr_fire && !pend_v[0]))
      |=> run_flag[0] && count[0] == $past(period[0])) else $error("no reload");
   chk_count_decrements: assert property (@(posedge clk) disable iff (srst)
      run_flag[0] && count[0] != '0 && !wr_fire |=> count[0] == $past(count[0]) - CW'(1))
      else $error("counter did not step");
   chk_count_bounded: assert property (@(posedge clk) disable iff (srst)
      count[0] <= period[0] || pend_v[0]) else $error("count above period");
   chk_flag_needs_expiry: assert property (@(posedge clk) disable iff (srst)
      $rose(irq_flag[0]) |-> $past(run_flag[0]) && $past(count[0]) == '0)
      else $error("flag rose without expiry");
   chk_stopped_holds: assert property (@(posedge clk) disable iff (srst)
      !run_flag[0] && !wr_fire |=> !run_flag[0] && $stable(count[0]))
      else $error("stopped channel moved");
   chk_channel_in_use_flag_holds: assert property (@(posedge clk) disable iff (srst)
      in_use[0] && !(wr_fire && aw_q == `MDT_OFF_CHANNEL_IN_USE_FLAG) |=> in_use[0])
      else $error("in-use dropped without release");
   chk_write_answer: assert property (@(posedge clk) disable iff (srst)
      wr_fire |=> s_axi_bvalid) else $error("write not answered");
endmodule // mdt_timer

// [logic/mdt_map.svh]
/*
 multi-channel down timer: register offsets, field positions and response codes.
 assumes inclusion by the timer module and its bench only.
*/
`ifndef MDT_MAP_SVH
`define MDT_MAP_SVH
// channel register block: 16 bytes per channel, channel n at n*16
`define MDT_CH_STRIDE      32'h0000_0010
`define MDT_OFF_PERIOD     4'h0
`define MDT_OFF_COUNT      4'h4
`define MDT_OFF_CTRL       4'h8
`define MDT_OFF_STAT       4'hC
// global registers
`define MDT_OFF_MODULE_CONFIG     8'hF0
`define MDT_OFF_IDLE       8'hF4
`define MDT_OFF_CHANNEL_IN_USE_FLAG      8'hF8
// field positions
`define MDT_CNT_W          24
`define MDT_LOAD_BIT       31
`define MDT_CTRL_IE_BIT    0
`define MDT_CTRL_MODE_LO   1
`define MDT_PERIOD_DEFER_BIT 30
`define MDT_CTRL_STOP_BIT  4
`define MDT_STAT_IRQ_BIT   0
`define MDT_STAT_RUN_BIT   1
`define MDT_NUM_CH         4
`define MDT_RESP_OKAY      2'h0
`define MDT_RESP_SLVERR    2'h2
`endif

// [logic/mdt_pkg.sv]
/*
 multi-channel down timer types.
 assumes nothing beyond the timer module and the bench that import it.
*/
package mdt_pkg;
   // channel modes, as held in the mode field
   typedef enum logic [1:0] {
      MDT_REPEAT_INTERRUPT_MODE   = 2'h0,
      MDT_ONE_SHOT_INTERRUPT_MODE = 2'h1,
      MDT_ONE_SHOT_STALL_MODE     = 2'h2
   } mdt_mode_t;
   // bus slave states, one-hot
   typedef enum logic [2:0] {
      MDT_BUS_IDLE  = 3'b001,
      MDT_BUS_BRESP = 3'b010,
      MDT_BUS_RRESP = 3'b100
   } mdt_bus_t;
endpackage

// [dv/tb_mdt_timer.sv]
/*
 bench for the multi-channel down timer: axi4-lite tasks and directed tests.
 assumes the timer answers every access and that assertions sit in the design.
*/
`timescale 1ns/100ps
`include "mdt_map.svh"
module tb_mdt_timer
   import mdt_pkg::*;
;
   logic        clk = 1'b0;            // 25 MHz bench clock
   logic        srst = 1'b1;           // synchronous reset
   logic [7:0]  awaddr = 8'h00;        // write address
   logic        awvalid = 1'b0;        // write address valid
   logic        awready;               // write address ready
   logic [31:0] wdata = 32'h0;         // write data
   logic        wvalid = 1'b0;         // write data valid
   logic        wready;                // write data ready
   logic [1:0]  bresp;                 // write response
   logic        bvalid;                // write response valid
   logic        bready = 1'b0;         // write response ready
   logic [7:0]  araddr = 8'h00;        // read address
   logic        arvalid = 1'b0;        // read address valid
   logic        arready;               // read address ready
   logic [31:0] rdata;                 // read data
   logic [1:0]  rresp;                 // read response
   logic        rvalid;                // read valid
   logic        rready = 1'b0;         // read ready
   logic [3:0]  chan_irq;              // interrupt requests
   int          n_mismatch = 0;        // mismatches seen
   int          n_checks = 0;          // comparisons made
   logic [31:0] d;                     // scratch read data
   logic [1:0]  r;                     // scratch response

   // half period of 20 ns
   always #20 clk = ~clk;

   mdt_timer DUT (.clk(clk), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .chan_irq(chan_irq));

   // verdict and end of run, also reached from any timeout
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic timeout(input string nm);
      n_mismatch++;
      $display("mismatch %s expected handshake seen none", nm);
      conclude();
   endtask

   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // range compare for a live count that moves while we read it
   task automatic check_rng(input string nm, input int lo, input int hi, input logic [31:0] got);
      n_checks++;
      if ((^got === 1'bx) || got < lo || got > hi) begin
         n_mismatch++;
         $display("mismatch %s expected %0d..%0d seen %h", nm, lo, hi, got);
      end
   endtask

   // byte address of a channel register
   function automatic logic [7:0] ra(input int ch, input logic [3:0] off);
      return {ch[3:0], off};
   endfunction

   // ready is looked at on the falling edge; inputs only move on rising ones,
   // so that value is the one sampled at the next rising edge
   task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
      logic pa, pw, ta, tw;
      int   n;
      @(posedge clk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= v;
      wvalid <= 1'b1;
      bready <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      for (n = 0; n < 50 && (pa || pw); n++) begin
         @(negedge clk);
         ta = pa && (awready === 1'b1);
         tw = pw && (wready === 1'b1);
         @(posedge clk);
         if (ta) begin
            awvalid <= 1'b0;
            pa = 1'b0;
         end
         if (tw) begin
            wvalid <= 1'b0;
            pw = 1'b0;
         end
      end
      if (pa || pw) timeout("write address/data");
      for (n = 0; n < 50; n++) begin
         @(negedge clk);
         if (bvalid === 1'b1) break;
      end
      if (n == 50) timeout("write response");
      resp = bresp;
      @(posedge clk);
      bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
      int n;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(negedge clk);
         if (arready === 1'b1) break;
      end
      if (n == 50) timeout("read address");
      @(posedge clk);
      arvalid <= 1'b0;
      for (n = 0; n < 50; n++) begin
         @(negedge clk);
         if (rvalid === 1'b1) break;
      end
      if (n == 50) timeout("read data");
      v = rdata;
      resp = rresp;
      @(posedge clk);
      rready <= 1'b0;
   endtask

   // ordinary accesses expect an okay response
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [1:0] rs;
      axi_write(a, v, rs);
      check($sformatf("bresp %h", a), `MDT_RESP_OKAY, {30'h0, rs});
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      logic [1:0]  rs;
      axi_read(a, v, rs);
      check($sformatf("rresp %h", a), `MDT_RESP_OKAY, {30'h0, rs});
      check($sformatf("rdata %h", a), exp, v);
   endtask

   // bounded wait for a channel request to rise
   task automatic wait_irq(input int ch, input int lim);
      int n;
      for (n = 0; n < lim; n++) begin
         @(negedge clk);
         if (chan_irq[ch] === 1'b1) break;
      end
      if (n == lim) timeout($sformatf("chan_irq %0d", ch));
   endtask

   initial begin
      int i;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      for (i = 0; i < 4; i++) begin
         rd_chk(ra(i, `MDT_OFF_CTRL), 32'h0);
         rd_chk(ra(i, `MDT_OFF_STAT), 32'h0);
         rd_chk(ra(i, `MDT_OFF_COUNT), 32'h0);
      end
      rd_chk(`MDT_OFF_MODULE_CONFIG, 32'h0);
      rd_chk(`MDT_OFF_CHANNEL_IN_USE_FLAG, 32'h0);
      check("chan_irq", 32'h0, {28'h0, chan_irq});
      // unmapped place answers with slave error
      axi_read(8'hE0, d, r);
      check("unmapped rresp", `MDT_RESP_SLVERR, {30'h0, r});
      check("unmapped rdata", 32'h0, d);
      axi_write(8'hE0, 32'hFFFF_FFFF, r);
      check("unmapped bresp", `MDT_RESP_SLVERR, {30'h0, r});
      // each channel its own mode and enable
      for (i = 0; i < 4; i++) wr(ra(i, `MDT_OFF_CTRL), (i << 1) | (i & 1));
      for (i = 0; i < 4; i++) rd_chk(ra(i, `MDT_OFF_CTRL), (i == 3) ? 1 : (i << 1) | (i & 1));
      for (i = 0; i < 4; i++) wr(ra(i, `MDT_OFF_CTRL), 32'h0);
      rd_chk(ra(1, `MDT_OFF_CTRL), 32'h0);
      wr(ra(0, `MDT_OFF_CTRL), 32'h1);
      wr(ra(0, `MDT_OFF_PERIOD), 32'd20);
      rd_chk(ra(0, `MDT_OFF_STAT), 32'h2);
      wait_irq(0, 100);
      rd_chk(ra(0, `MDT_OFF_STAT), 32'h3);
      // mask write clears only the flag
      wr(ra(0, `MDT_OFF_STAT), 32'h1);
      rd_chk(ra(0, `MDT_OFF_STAT), 32'h2);
      @(negedge clk);
      check("irq after clear", 32'h0, {31'h0, chan_irq[0]});
      wait_irq(0, 100);
      // enable gates the request, flag stays
      wr(ra(0, `MDT_OFF_CTRL), 32'h0);
      @(negedge clk);
      check("irq masked", 32'h0, {31'h0, chan_irq[0]});
      rd_chk(ra(0, `MDT_OFF_STAT), 32'h3);
      wr(ra(0, `MDT_OFF_CTRL), 32'h1 << `MDT_CTRL_STOP_BIT);
      wr(ra(0, `MDT_OFF_STAT), 32'h1);
      repeat (60) @(posedge clk);
      rd_chk(ra(0, `MDT_OFF_STAT), 32'h0);
      rd_chk(ra(0, `MDT_OFF_COUNT), 32'h0);
      // one-shot modes count once then stop
      for (i = 1; i <= 2; i++) begin
         wr(ra(i, `MDT_OFF_CTRL), (i << 1) | 1);
         wr(ra(i, `MDT_OFF_PERIOD), 32'd10);
         wait_irq(i, 60);
         repeat (40) @(posedge clk);
         rd_chk(ra(i, `MDT_OFF_STAT), 32'h1);
         rd_chk(ra(i, `MDT_OFF_COUNT), 32'h0);
         wr(ra(i, `MDT_OFF_STAT), 32'h1);
      end
      wr(ra(3, `MDT_OFF_PERIOD), 32'd200);
      wr(ra(3, `MDT_OFF_PERIOD), 32'h4000_0005);
      axi_read(ra(3, `MDT_OFF_COUNT), d, r);
      check_rng("deferred count", 6, 200, d);
      // let the running interval finish so the deferred period takes over
      repeat (200) @(posedge clk);
      rd_chk(ra(3, `MDT_OFF_PERIOD), 32'd5);
      wr(ra(3, `MDT_OFF_PERIOD), 32'd100);
      axi_read(ra(3, `MDT_OFF_COUNT), d, r);
      check_rng("immediate count", 0, 100, d);
      wr(ra(3, `MDT_OFF_PERIOD), 32'hC000_0028);
      axi_read(ra(3, `MDT_OFF_COUNT), d, r);
      check_rng("forced count", 0, 40, d);
      rd_chk(ra(3, `MDT_OFF_PERIOD), 32'd40);
      // one-shot interrupt mode ignores the deferral
      wr(ra(1, `MDT_OFF_PERIOD), 32'd200);
      wr(ra(1, `MDT_OFF_PERIOD), 32'h4000_0005);
      axi_read(ra(1, `MDT_OFF_COUNT), d, r);
      check_rng("one-shot count", 0, 5, d);
      wr(ra(1, `MDT_OFF_CTRL), 32'h1 << `MDT_CTRL_STOP_BIT);
      wr(ra(3, `MDT_OFF_CTRL), 32'h1 << `MDT_CTRL_STOP_BIT);
      // hardware-status mode: free means not running
      wr(ra(0, `MDT_OFF_PERIOD), 32'd200);
      rd_chk(`MDT_OFF_IDLE, 32'h1);
      wr(ra(0, `MDT_OFF_CTRL), 32'h1 << `MDT_CTRL_STOP_BIT);
      rd_chk(`MDT_OFF_IDLE, 32'h0);
      wr(`MDT_OFF_MODULE_CONFIG, 32'h1);
      for (i = 0; i < 4; i++) begin
         rd_chk(`MDT_OFF_IDLE, i);
         rd_chk(`MDT_OFF_CHANNEL_IN_USE_FLAG, (1 << (i + 1)) - 1);
      end
      rd_chk(`MDT_OFF_IDLE, 32'h4);
      wr(`MDT_OFF_CHANNEL_IN_USE_FLAG, 32'h2);
      rd_chk(`MDT_OFF_CHANNEL_IN_USE_FLAG, 32'hD);
      rd_chk(`MDT_OFF_IDLE, 32'h1);
      rd_chk(`MDT_OFF_CHANNEL_IN_USE_FLAG, 32'hF);
      conclude();
   end
endmodule // tb_mdt_timer
